/* File: rtl/ftc_pkg.sv */
// constants, register map and carrier types of the fan tachometer block
// assumes a 50 MHz core clock and an 8-bit register port
package ftc_pkg;

  // timing
  localparam int unsigned FTC_CLK_HZ = 50_000_000;
  localparam int unsigned FTC_QUARTER_MS = 250;
  localparam int unsigned FTC_QUARTER_CYCLES =
    FTC_QUARTER_MS * (FTC_CLK_HZ / 1000);

  // register offsets
  localparam logic [7:0] FTC_ADDR_WINDOW = 8'h00;
  localparam logic [7:0] FTC_ADDR_COUNT = 8'h01;
  localparam logic [7:0] FTC_ADDR_DAC = 8'h02;
  localparam logic [7:0] FTC_ADDR_MODE = 8'h03;
  localparam logic [7:0] FTC_ADDR_ALM_EN = 8'h04;
  localparam logic [7:0] FTC_ADDR_ALM_ST = 8'h05;

  // field layout
  localparam int unsigned FTC_WIN_LSB = 0;
  localparam int unsigned FTC_MODE_LSB = 0;
  localparam int unsigned FTC_PRESC_LSB = 2;
  localparam int unsigned FTC_ALM_SPEED_PULSE_INPUT_BIT = 2;

  // reset values
  localparam logic [1:0] FTC_WIN_RST = 2'h2;
  localparam logic [7:0] FTC_COUNT_RST = 8'h00;
  localparam logic [7:0] FTC_DAC_RST = 8'h00;
  localparam logic [2:0] FTC_PRESC_RST = 3'h2;
  localparam logic FTC_ALM_EN_RST = 1'b0;

  // drive mode codes
  localparam logic [1:0] FTC_MODE_FULL = 2'h0;
  localparam logic [1:0] FTC_MODE_OFF = 2'h1;
  localparam logic [1:0] FTC_MODE_CLOSED = 2'h2;
  localparam logic [1:0] FTC_MODE_OPEN = 2'h3;
  localparam logic [1:0] FTC_MODE_RST = FTC_MODE_FULL;

  // drive codes and count limit
  localparam logic [7:0] FTC_FULL_CODE = 8'hFF;
  localparam logic [7:0] FTC_OFF_CODE = 8'h00;
  localparam logic [7:0] FTC_COUNT_MAX = 8'hFF;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ftc_bus_req_t;

  typedef struct packed {
    logic [7:0] count;
    logic ovf;
    logic done;
  } ftc_speed_pulse_input_t;

endpackage : ftc_pkg

/* File: rtl/ftc_pulse_counter.sv */
// tachometer pulse counter: synchronises the pin, counts rising edges
// and publishes a saturated count with overflow at each period end
// assumes period_end and restart are single-cycle pulses on clock
`timescale 1ns/10ps
module ftc_pulse_counter
  import ftc_pkg::*;
(
  input wire logic clock, // core clock
  input wire logic arst_n, // async reset, active low
  input wire logic speed_pulse_input, // tachometer pin, asynchronous
  input wire logic restart, // drop partial count, publish nothing
  input wire logic period_end, // close the integration period
  output ftc_speed_pulse_input_t result // published count, one-cycle done
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [7:0] cnt;
    logic ovf;
    ftc_speed_pulse_input_t res;
  } ftc_cnt_state_t;

  ftc_cnt_state_t st_r;
  ftc_cnt_state_t st_nxt;
  logic edge_seen;
  logic [7:0] cnt_inc;
  logic ovf_inc;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = speed_pulse_input;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    edge_seen = st_r.sync2 & ~st_r.prev;
    cnt_inc = st_r.cnt;
    ovf_inc = st_r.ovf;
    if (edge_seen) begin
      if (st_r.cnt == FTC_COUNT_MAX) begin
        ovf_inc = 1'b1; // RQ14
      end else begin
        cnt_inc = st_r.cnt + 8'h01; // RQ13
      end
    end
    st_nxt.res.done = 1'b0;
    if (restart) begin
      st_nxt.cnt = FTC_COUNT_RST;
      st_nxt.ovf = 1'b0;
    end else if (period_end) begin
      st_nxt.res.count = cnt_inc; // RQ15
      st_nxt.res.ovf = ovf_inc;
      st_nxt.res.done = 1'b1;
      st_nxt.cnt = FTC_COUNT_RST;
      st_nxt.ovf = 1'b0;
    end else begin
      st_nxt.cnt = cnt_inc;
      st_nxt.ovf = ovf_inc;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign result = st_r.res;

  sat_hold_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ14
    (st_r.cnt == FTC_COUNT_MAX && !restart && !period_end)
    |=> (st_r.cnt == FTC_COUNT_MAX))
    else $error("pulse count wrapped past its maximum");

  ovf_sat_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ14
    (st_r.res.done && st_r.res.ovf) |-> (st_r.res.count == FTC_COUNT_MAX))
    else $error("overflow published without a saturated count");

endmodule : ftc_pulse_counter

/* File: rtl/ftc_top.sv */
// fan tachometer count window, drive-code register and power-up defaults
// assumes a register master on the same clock and an async pin for the
// tachometer; the closed-loop code comes from loop logic on this clock
//
// Contract
// RQ1: count-window register reads zero in its six upper bits.
// RQ2: integration period is 0.25 s times two to the selector.
// RQ3: pulse-count register is zero after power-up.
// RQ4: count-window selector powers up at the one-second period.
// RQ5: open-loop drive uses the eight-bit drive register as reference.
// RQ6: closed-loop drive ignores the written drive register.
// RQ7: host waits 500 us after a drive write before reading it.
// RQ8: every alarm is disabled after power-up.
// RQ9: prescale ratio powers up at four.
// RQ10: fan powers up in full-on drive mode.
// RQ11: supply loss detector resets all registers to their defaults.
// RQ12: software should keep open-loop drive codes within 08h to B0h.
// RQ13: pulse count holds the edges seen in one period.
// RQ14: above 255 pulses the count saturates and overflow alarm sets.
// RQ15: pulse count updates once per period and holds until the next.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/10ps
module ftc_top
  import ftc_pkg::*;
#(
  parameter int unsigned QUARTER_CYCLES = FTC_QUARTER_CYCLES
) (
  input wire logic clock, // 50 MHz core clock
  input wire logic arst_n, // power-on reset, active low
  input ftc_bus_req_t bus_req, // register port request
  output logic [7:0] rd_data, // read data, cycle after the read
  output logic irq, // level interrupt, unmasked alarm
  input wire logic speed_pulse_input, // tachometer pin
  input wire logic [7:0] closed_loop_code, // loop drive reference
  output logic [7:0] drive_code, // reference to the drive stage
  output logic closed_loop_en // speed loop is in control
);

  typedef struct packed {
    logic [1:0] win_sel;
    logic [7:0] dac;
    logic [1:0] mode;
    logic [2:0] presc;
    logic alm_en;
    logic alm_st;
    logic [7:0] count;
    logic [31:0] qcnt;
    logic [3:0] quarters;
    logic period_end;
    logic [7:0] drive;
    logic loop_en;
    logic [7:0] rdata;
    logic irq;
  } ftc_state_t;

  ftc_state_t st_r;
  ftc_state_t st_nxt;
  ftc_speed_pulse_input_t speed_pulse_input_res;
  logic win_wr;
  logic [3:0] last_quarter;
  logic [7:0] rd_mux;
  logic alm_clr;

  ftc_pulse_counter u_counter (
    .clock(clock),
    .arst_n(arst_n),
    .speed_pulse_input(speed_pulse_input),
    .restart(win_wr),
    .period_end(st_r.period_end),
    .result(speed_pulse_input_res)
  );

  always_comb begin
    st_nxt = st_r;
    win_wr = bus_req.wr && (bus_req.addr == FTC_ADDR_WINDOW);
    alm_clr = bus_req.wr && (bus_req.addr == FTC_ADDR_ALM_ST)
      && bus_req.wdata[FTC_ALM_SPEED_PULSE_INPUT_BIT];
    last_quarter = 4'((5'h01 << st_r.win_sel) - 5'h01);

    // register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        FTC_ADDR_WINDOW: begin
          st_nxt.win_sel = bus_req.wdata[FTC_WIN_LSB +: 2];
        end
        FTC_ADDR_DAC: begin
          st_nxt.dac = bus_req.wdata;
        end
        FTC_ADDR_MODE: begin
          st_nxt.mode = bus_req.wdata[FTC_MODE_LSB +: 2];
          st_nxt.presc = bus_req.wdata[FTC_PRESC_LSB +: 3];
        end
        FTC_ADDR_ALM_EN: begin
          st_nxt.alm_en = bus_req.wdata[FTC_ALM_SPEED_PULSE_INPUT_BIT];
        end
        default: begin
        end
      endcase
    end

    // integration period timer, counted in quarter-second steps
    st_nxt.period_end = 1'b0;
    if (win_wr) begin
      // a new selector restarts the window so no period mixes two lengths
      st_nxt.qcnt = '0;
      st_nxt.quarters = '0;
    end else if (st_r.qcnt == QUARTER_CYCLES - 1) begin
      st_nxt.qcnt = '0;
      if (st_r.quarters >= last_quarter) begin
        st_nxt.quarters = '0;
        st_nxt.period_end = 1'b1; // RQ2
      end else begin
        st_nxt.quarters = st_r.quarters + 4'h1;
      end
    end else begin
      st_nxt.qcnt = st_r.qcnt + 32'h1;
    end

    // published count and overflow alarm; a new event beats the clear
    if (speed_pulse_input_res.done) begin
      st_nxt.count = speed_pulse_input_res.count; // RQ15
    end
    st_nxt.alm_st = (st_r.alm_st & ~alm_clr)
      | (speed_pulse_input_res.done & speed_pulse_input_res.ovf); // RQ14
    st_nxt.irq = st_r.alm_st & st_r.alm_en; // RQ8

    // drive reference selection
    st_nxt.loop_en = (st_r.mode == FTC_MODE_CLOSED);
    case (st_r.mode)
      FTC_MODE_FULL: st_nxt.drive = FTC_FULL_CODE; // RQ10
      FTC_MODE_OFF: st_nxt.drive = FTC_OFF_CODE;
      FTC_MODE_CLOSED: st_nxt.drive = closed_loop_code; // RQ6
      FTC_MODE_OPEN: st_nxt.drive = st_r.dac; // RQ5
      default: st_nxt.drive = FTC_FULL_CODE;
    endcase

    // register reads, data valid only in the following cycle
    case (bus_req.addr)
      FTC_ADDR_WINDOW: rd_mux = {6'h00, st_r.win_sel}; // RQ1
      FTC_ADDR_COUNT: rd_mux = st_r.count;
      // in closed loop the active loop value is shown, not the stored code
      FTC_ADDR_DAC: rd_mux = st_r.loop_en ? st_r.drive : st_r.dac;
      FTC_ADDR_MODE: rd_mux = {3'h0, st_r.presc, st_r.mode};
      FTC_ADDR_ALM_EN: rd_mux = 8'(st_r.alm_en) << FTC_ALM_SPEED_PULSE_INPUT_BIT;
      FTC_ADDR_ALM_ST: rd_mux = 8'(st_r.alm_st) << FTC_ALM_SPEED_PULSE_INPUT_BIT;
      default: rd_mux = 8'h00;
    endcase
    st_nxt.rdata = bus_req.rd ? rd_mux : 8'h00;
  end

  // the reset input is the supply-loss detector: everything returns home
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0; // RQ11
      st_r.win_sel <= FTC_WIN_RST; // RQ4
      st_r.count <= FTC_COUNT_RST; // RQ3
      st_r.dac <= FTC_DAC_RST;
      st_r.mode <= FTC_MODE_RST; // RQ10
      st_r.presc <= FTC_PRESC_RST; // RQ9
      st_r.alm_en <= FTC_ALM_EN_RST; // RQ8
      st_r.drive <= FTC_FULL_CODE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data = st_r.rdata;
  assign irq = st_r.irq;
  assign drive_code = st_r.drive;
  assign closed_loop_en = st_r.loop_en;

  // helper logic for the checks below
  logic por_seen_r;
  logic [31:0] per_cyc_r;
  logic [31:0] per_len;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      por_seen_r <= 1'b0;
      per_cyc_r <= '0;
    end else begin
      por_seen_r <= 1'b1;
      if (win_wr) begin
        per_cyc_r <= '0;
      end else if (st_r.period_end) begin
        per_cyc_r <= 32'h1;
      end else begin
        per_cyc_r <= per_cyc_r + 32'h1;
      end
    end
  end

  assign per_len = QUARTER_CYCLES << st_r.win_sel;

  win_read_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ1
    (bus_req.rd && bus_req.addr == FTC_ADDR_WINDOW)
    |=> (rd_data[7:2] == 6'h00 && rd_data[1:0] == $past(st_r.win_sel)))
    else $error("window read shows wrong bits");

  period_len_a: assert property (@(posedge clock) disable iff (!arst_n) // RQ2
    st_r.period_end |-> (per_cyc_r == per_len))
    else $error("integration period has the wrong length");

  por_defaults_a: assert property ( // RQ3
    @(posedge clock) disable iff (!arst_n)
    !por_seen_r |-> (st_r.count == FTC_COUNT_RST
      && st_r.win_sel == FTC_WIN_RST && st_r.presc == FTC_PRESC_RST
      && st_r.alm_en == 1'b0 && st_r.mode == FTC_MODE_FULL
      && drive_code == FTC_FULL_CODE))
    else $error("power-up defaults not in place");

  open_drive_a: assert property ( // RQ5
    @(posedge clock) disable iff (!arst_n)
    (st_r.mode == FTC_MODE_OPEN) |=> (drive_code == $past(st_r.dac)))
    else $error("open-loop drive does not follow the drive register");

  closed_drive_a: assert property ( // RQ6
    @(posedge clock) disable iff (!arst_n)
    (st_r.mode == FTC_MODE_CLOSED)
    |=> (drive_code == $past(closed_loop_code) && closed_loop_en))
    else $error("closed-loop drive not taken from the loop");

  count_hold_a: assert property ( // RQ15
    @(posedge clock) disable iff (!arst_n)
    !speed_pulse_input_res.done |=> $stable(st_r.count))
    else $error("pulse count changed outside a period end");

  count_pub_a: assert property ( // RQ13
    @(posedge clock) disable iff (!arst_n)
    st_r.period_end && !win_wr ##1 1'b1
    |-> speed_pulse_input_res.done ##1 (st_r.count == $past(speed_pulse_input_res.count)))
    else $error("period end did not publish a count");

  ovf_alarm_a: assert property ( // RQ14
    @(posedge clock) disable iff (!arst_n)
    (speed_pulse_input_res.done && speed_pulse_input_res.ovf) |=> st_r.alm_st)
    else $error("overflow did not set the alarm, or a clear won");

  irq_gate_a: assert property ( // RQ8
    @(posedge clock) disable iff (!arst_n)
    st_r.alm_st && !st_r.alm_en |=> !irq)
    else $error("masked alarm reached the interrupt");

  rd_idle_a: assert property (@(posedge clock) disable iff (!arst_n)
    !bus_req.rd |=> (rd_data == 8'h00))
    else $error("read data present without a read");

  period_cover_c: cover property (@(posedge clock) disable iff (!arst_n)
    speed_pulse_input_res.done && speed_pulse_input_res.count != 8'h00);

  ovf_cover_c: cover property (@(posedge clock) disable iff (!arst_n)
    speed_pulse_input_res.done && speed_pulse_input_res.ovf ##2 irq);

  open_cover_c: cover property (@(posedge clock) disable iff (!arst_n)
    st_r.mode == FTC_MODE_OPEN ##1 drive_code == st_r.dac);

  clear_cover_c: cover property (@(posedge clock) disable iff (!arst_n)
    st_r.alm_st && alm_clr ##1 !st_r.alm_st);

  window_cover_c: cover property (@(posedge clock) disable iff (!arst_n)
    win_wr ##1 st_r.win_sel == 2'h3);

  // register port, alarm, drive and timer checks; the port answers a cycle late
  irq_set_a: assert property ( // RQ14
    @(posedge clock) disable iff (!arst_n)
    (st_r.alm_st && st_r.alm_en) |=> irq)
    else $error("enabled alarm did not raise the interrupt");

  irq_drop_a: assert property ( // RQ8
    @(posedge clock) disable iff (!arst_n)
    !st_r.alm_st |=> !irq)
    else $error("interrupt raised with no alarm pending");

  alarm_clear_a: assert property ( // RQ14
    @(posedge clock) disable iff (!arst_n)
    (alm_clr && !(speed_pulse_input_res.done && speed_pulse_input_res.ovf)) |=> !st_r.alm_st)
    else $error("alarm status survived a clear");

  full_drive_a: assert property ( // RQ10
    @(posedge clock) disable iff (!arst_n)
    (st_r.mode == FTC_MODE_FULL) |=> (drive_code == FTC_FULL_CODE))
    else $error("full-on mode does not drive the top code");

  off_drive_a: assert property (@(posedge clock) disable iff (!arst_n)
    (st_r.mode == FTC_MODE_OFF) |=> (drive_code == FTC_OFF_CODE))
    else $error("off mode still drives the fan");

  loop_flag_a: assert property ( // RQ6
    @(posedge clock) disable iff (!arst_n)
    (st_r.mode != FTC_MODE_CLOSED) |=> !closed_loop_en)
    else $error("loop flag set outside closed-loop mode");

  mode_hold_a: assert property ( // RQ10
    @(posedge clock) disable iff (!arst_n)
    !(bus_req.wr && bus_req.addr == FTC_ADDR_MODE) |=> $stable(st_r.mode))
    else $error("drive mode changed without a write");

  sel_hold_a: assert property ( // RQ4
    @(posedge clock) disable iff (!arst_n)
    !win_wr |=> $stable(st_r.win_sel))
    else $error("window selector changed without a write");

  count_read_a: assert property ( // RQ13
    @(posedge clock) disable iff (!arst_n)
    (bus_req.rd && bus_req.addr == FTC_ADDR_COUNT)
    |=> (rd_data == $past(st_r.count)))
    else $error("count read does not show the published count");

  dac_write_a: assert property ( // RQ5
    @(posedge clock) disable iff (!arst_n)
    (bus_req.wr && bus_req.addr == FTC_ADDR_DAC)
    |=> (st_r.dac == $past(bus_req.wdata)))
    else $error("drive register write lost");

  dac_read_a: assert property ( // RQ5
    @(posedge clock) disable iff (!arst_n)
    (bus_req.rd && bus_req.addr == FTC_ADDR_DAC && !st_r.loop_en)
    |=> (rd_data == $past(st_r.dac)))
    else $error("drive register read back wrong");

  mode_read_a: assert property ( // RQ9
    @(posedge clock) disable iff (!arst_n)
    (bus_req.rd && bus_req.addr == FTC_ADDR_MODE)
    |=> (rd_data == {3'h0, $past(st_r.presc), $past(st_r.mode)}))
    else $error("mode register read back wrong");

  alm_read_a: assert property ( // RQ8
    @(posedge clock) disable iff (!arst_n)
    (bus_req.rd && bus_req.addr == FTC_ADDR_ALM_EN)
    |=> (rd_data == (8'($past(st_r.alm_en)) << FTC_ALM_SPEED_PULSE_INPUT_BIT)))
    else $error("alarm enable read back wrong");

  status_read_a: assert property ( // RQ14
    @(posedge clock) disable iff (!arst_n)
    (bus_req.rd && bus_req.addr == FTC_ADDR_ALM_ST)
    |=> (rd_data == (8'($past(st_r.alm_st)) << FTC_ALM_SPEED_PULSE_INPUT_BIT)))
    else $error("alarm status read back wrong");

  win_write_a: assert property ( // RQ2
    @(posedge clock) disable iff (!arst_n)
    win_wr |=> (st_r.win_sel == $past(bus_req.wdata[FTC_WIN_LSB +: 2])
      && st_r.qcnt == 32'h0 && st_r.quarters == 4'h0))
    else $error("window write did not restart the period");

  quarter_bound_a: assert property ( // RQ2
    @(posedge clock) disable iff (!arst_n)
    st_r.qcnt < QUARTER_CYCLES)
    else $error("quarter timer ran past its end");

  end_pulse_a: assert property ( // RQ15
    @(posedge clock) disable iff (!arst_n)
    st_r.period_end |=> !st_r.period_end)
    else $error("period end lasted more than one cycle");

endmodule : ftc_top

/* File: verification/ftc_fan_model.sv */
// fan tachometer model: bursts of rising edges on the speed pulse pin
// assumes fire is a one-cycle request launched after a rising clock edge
`timescale 1ns/10ps
module ftc_fan_model (
  input wire logic clock, // core clock
  input wire logic fire, // start a burst
  input wire logic [9:0] burst_len, // pulses in the burst
  output logic speed_pulse_input // tachometer pin
);
  // two clocks high and two low keep each level past the synchroniser
  initial begin
    speed_pulse_input = 1'b0;
    forever begin
      @(posedge clock);
      if (fire === 1'b1) begin
        repeat (burst_len) begin
          speed_pulse_input <= 1'b1;
          repeat (2) @(posedge clock);
          speed_pulse_input <= 1'b0;
          repeat (2) @(posedge clock);
        end
      end
    end
  end
endmodule : ftc_fan_model

/* File: verification/ftc_top_bench.sv */
// self-checking bench of the fan tachometer block
// assumes a short quarter period; the fan model drives the pulse pin
`timescale 1ns/10ps
module ftc_top_bench;
  import ftc_pkg::*;
  localparam int unsigned QC = 500;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  ftc_bus_req_t bus_req = '0;
  logic [7:0] rd_data, drive_code, v;
  logic irq, closed_loop_en, pin, fire = 1'b0;
  logic [7:0] closed_loop_code = 8'h5A;
  logic [9:0] burst_len = 10'h000;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0;
  always #10 clock = ~clock;
  ftc_top #(.QUARTER_CYCLES(QC)) ftc_top_inst (.clock(clock),
    .arst_n(arst_n), .bus_req(bus_req), .rd_data(rd_data), .irq(irq),
    .speed_pulse_input(pin), .closed_loop_code(closed_loop_code),
    .drive_code(drive_code), .closed_loop_en(closed_loop_en));
  ftc_fan_model ftc_fan_model_inst (.clock(clock), .fire(fire),
    .burst_len(burst_len), .speed_pulse_input(pin));
  task tally_and_finish();
    $display("compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  // the ceiling allows about twice the expected run
  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp, input string s);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask : rd
  task rchk(input logic [7:0] a, input logic [7:0] exp, input string s);
    rd(a, v);
    chk(v, exp, s);
  endtask : rchk
  task burst(input logic [9:0] n);
    @(posedge clock);
    fire <= 1'b1;
    burst_len <= n;
    @(posedge clock);
    fire <= 1'b0;
  endtask : burst
  task settle();
    repeat (3) @(posedge clock);
    #1;
  endtask : settle
  task do_reset();
    arst_n <= 1'b0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
  endtask : do_reset
  task t_defaults();
    #1 chk(drive_code, 8'hFF, "full drive");
    chk({7'h00, irq}, 8'h00, "irq quiet");
    chk({7'h00, closed_loop_en}, 8'h00, "loop off");
    rchk(FTC_ADDR_WINDOW, 8'h02, "window one second");
    rchk(FTC_ADDR_COUNT, 8'h00, "count clear");
    rchk(FTC_ADDR_MODE, 8'h08, "prescale four, full mode");
    rchk(FTC_ADDR_ALM_EN, 8'h00, "alarms off");
    rchk(FTC_ADDR_ALM_ST, 8'h00, "status clear");
    rchk(8'h3C, 8'h00, "unmapped");
  endtask : t_defaults
  task t_window_bits();
    wr(FTC_ADDR_WINDOW, 8'hFF);
    rchk(FTC_ADDR_WINDOW, 8'h03, "upper bits zero");
    wr(FTC_ADDR_WINDOW, 8'hFC);
    rchk(FTC_ADDR_WINDOW, 8'h00, "selector only");
  endtask : t_window_bits
  task t_period();
    int unsigned len;
    logic [7:0] n;
    for (int s = 0; s < 4; s++) begin
      len = QC << s;
      n = 8'(3 + s);
      wr(FTC_ADDR_WINDOW, 8'(s));
      t0 = cyc;
      burst(10'(n));
      v = 8'h00;
      while (v !== n && cyc - t0 < len + 40) rd(FTC_ADDR_COUNT, v);
      chk(v, n, "pulses in period");
      chk(8'(cyc - t0 >= len && cyc - t0 <= len + 8), 8'h01, "period");
      repeat (len / 2) @(posedge clock);
      rchk(FTC_ADDR_COUNT, n, "count holds");
      repeat (len / 2 + 8) @(posedge clock);
      rchk(FTC_ADDR_COUNT, 8'h00, "idle period");
    end
  endtask : t_period
  task t_overflow();
    wr(FTC_ADDR_ALM_EN, 8'h04);
    wr(FTC_ADDR_WINDOW, 8'h02);
    burst(10'd255);
    repeat (4 * QC + 20) @(posedge clock);
    rchk(FTC_ADDR_COUNT, 8'hFF, "255 pulses");
    rchk(FTC_ADDR_ALM_ST, 8'h00, "no overflow at 255");
    wr(FTC_ADDR_WINDOW, 8'h02);
    burst(10'd256);
    repeat (4 * QC + 20) @(posedge clock);
    rchk(FTC_ADDR_COUNT, 8'hFF, "saturated");
    rchk(FTC_ADDR_ALM_ST, 8'h04, "overflow status");
    chk({7'h00, irq}, 8'h01, "irq raised");
    wr(FTC_ADDR_ALM_EN, 8'h00);
    settle();
    chk({7'h00, irq}, 8'h00, "irq masked");
    wr(FTC_ADDR_ALM_EN, 8'h04);
    settle();
    chk({7'h00, irq}, 8'h01, "irq unmasked");
    wr(FTC_ADDR_ALM_ST, 8'h04);
    settle();
    chk({7'h00, irq}, 8'h00, "irq cleared");
    rchk(FTC_ADDR_ALM_ST, 8'h00, "status cleared");
  endtask : t_overflow
  task t_drive();
    wr(FTC_ADDR_MODE, 8'h0A);
    wr(FTC_ADDR_DAC, 8'h40);
    repeat (25000) @(posedge clock);
    #1 chk(drive_code, 8'h5A, "closed ignores register");
    chk({7'h00, closed_loop_en}, 8'h01, "loop on");
    rchk(FTC_ADDR_DAC, 8'h5A, "active loop code");
    wr(FTC_ADDR_MODE, 8'h0B);
    settle();
    chk(drive_code, 8'h40, "open drive held");
    rchk(FTC_ADDR_DAC, 8'h40, "drive read back");
    // 08h and B0h bound the linear range of the drive stage
    for (int i = 0; i < 2; i++) begin
      wr(FTC_ADDR_DAC, i == 0 ? 8'h08 : 8'hB0);
      settle();
      chk(drive_code, i == 0 ? 8'h08 : 8'hB0, "open drive");
    end
    wr(FTC_ADDR_MODE, 8'h09);
    settle();
    chk(drive_code, 8'h00, "off mode");
    wr(FTC_ADDR_MODE, 8'h08);
    settle();
    chk(drive_code, 8'hFF, "full mode");
  endtask : t_drive
  task t_supply_loss();
    wr(FTC_ADDR_WINDOW, 8'h00);
    wr(FTC_ADDR_MODE, 8'h0B);
    wr(FTC_ADDR_ALM_EN, 8'h04);
    do_reset();
    t_defaults();
  endtask : t_supply_loss
  initial begin
    do_reset();
    t_defaults();
    t_window_bits();
    t_period();
    t_overflow();
    t_drive();
    t_supply_loss();
    tally_and_finish();
  end
endmodule : ftc_top_bench
